// ### hdl/dual_port_register_access.sv
`timescale 1ns/1ps
module dual_port_register_access
  import regacc_pkg::*;
#(
  parameter longint TIMEOUT_LIMIT = TIMEOUT_CYCLES
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic chip_select_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  input wire logic uart_rxd,
  output logic uart_txd
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
    end else begin
      sync1_q <= {chip_select_n, sck, mosi, uart_rxd};
      sync2_q <= sync1_q;
    end
  end
  logic sck_prev_q;
  wire cs_n_s = sync2_q[3];
  wire sck_s = sync2_q[2];
  wire mosi_s = sync2_q[1];
  wire rxd_s = sync2_q[0];
  wire sck_rise = sck_s & ~sck_prev_q & ~cs_n_s;
  wire sck_fall = ~sck_s & sck_prev_q & ~cs_n_s;
  // ------------------------------------------------------------
  // Register bank
  // ------------------------------------------------------------
  logic [31:0] ident_select_q;
  logic [31:0] uart_rate_q;
  logic [15:0] bit_div_q;
  reg_req_t spi_wr;
  reg_req_t uart_wr;
  logic spi_wr_go;
  logic uart_wr_go;
  function automatic logic [31:0] read_reg(input logic [6:0] a, input logic [31:0] sel,
                                           input logic [31:0] rate);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      ADDR_IDENT_VALUE: begin
        unique case (sel)
          32'h0000_0000: r = IDENT_WORD0;
          32'h0000_0001: r = IDENT_WORD1;
          default: r = IDENT_WORD2;
        endcase
      end
      ADDR_IDENT_SELECT: r = sel;
      ADDR_UART_RATE: r = rate;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : read_reg
  wire rate_code_ok = (uart_wr.data == RATE_9600_CODE) || (uart_wr.data == RATE_115200_CODE)
                   || (uart_wr.data == RATE_921600_CODE) || (uart_wr.data == RATE_3M_CODE);
  wire spi_rate_ok = (spi_wr.data == RATE_9600_CODE) || (spi_wr.data == RATE_115200_CODE)
                  || (spi_wr.data == RATE_921600_CODE) || (spi_wr.data == RATE_3M_CODE);
  // Serial port wins a same-cycle collision; the other write still lands on other regs
  wire spi_rate_wr = spi_wr_go && spi_wr.addr == ADDR_UART_RATE && spi_rate_ok;
  wire uart_rate_wr = uart_wr_go && uart_wr.addr == ADDR_UART_RATE && rate_code_ok;
  wire spi_sel_wr = spi_wr_go && spi_wr.addr == ADDR_IDENT_SELECT;
  wire uart_sel_wr = uart_wr_go && uart_wr.addr == ADDR_IDENT_SELECT;
  wire [31:0] new_rate = spi_rate_wr ? spi_wr.data : uart_wr.data;
  logic [15:0] div_d;
  always_comb begin
    unique case (uart_rate_q)
      RATE_115200_CODE: div_d = DIV_115200;
      RATE_921600_CODE: div_d = DIV_921600;
      RATE_3M_CODE: div_d = DIV_3M;
      default: div_d = DIV_9600;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ident_select_q <= IDENT_SELECT_RESET;
      uart_rate_q <= UART_RATE_RESET;
      bit_div_q <= DIV_9600;
    end else begin
      bit_div_q <= div_d;
      if (spi_rate_wr || uart_rate_wr) begin
        uart_rate_q <= new_rate;
      end
      if (spi_sel_wr) begin
        ident_select_q <= spi_wr.data;
      end else if (uart_sel_wr) begin
        ident_select_q <= uart_wr.data;
      end
    end
  end
  // ------------------------------------------------------------
  // Serial peripheral port
  // ------------------------------------------------------------
  logic [5:0] spi_cnt_q;
  logic [DGRAM_BITS-1:0] spi_in_q;
  logic [31:0] spi_out_q;
  wire [DGRAM_BITS-1:0] spi_in_d = {spi_in_q[DGRAM_BITS-2:0], mosi_s};
  wire spi_addr_done = sck_rise && spi_cnt_q == 6'd7;
  wire spi_last = sck_rise && spi_cnt_q == 6'(DGRAM_BITS - 1);
  wire [31:0] spi_rd = read_reg(spi_in_d[6:0], ident_select_q, uart_rate_q);
  always_ff @(posedge mclk) begin
    sck_prev_q <= sck_s;
    spi_wr_go <= 1'b0;
    if (!rst_n) begin
      spi_cnt_q <= 6'h00;
      spi_in_q <= '0;
      spi_out_q <= 32'h0000_0000;
      miso <= 1'b0;
      spi_wr <= '0;
      sck_prev_q <= 1'b1;
    end else if (cs_n_s) begin
      spi_cnt_q <= 6'h00;
    end else begin
      if (sck_rise) begin
        spi_in_q <= spi_in_d;
        spi_cnt_q <= spi_cnt_q + 6'h01;
      end
      if (spi_addr_done) begin
        spi_out_q <= spi_rd;
      end
      if (sck_fall && spi_cnt_q >= 6'd8 && spi_cnt_q < 6'(DGRAM_BITS)) begin
        miso <= spi_out_q[31];
        spi_out_q <= {spi_out_q[30:0], 1'b0};
      end else if (sck_fall && spi_cnt_q < 6'd8) begin
        miso <= 1'b0;
      end
      if (spi_last && spi_in_q[FLAG_POS-1]) begin
        spi_wr <= '{wr: 1'b1, addr: spi_in_q[ADDR_MSB-1:ADDR_LSB-1],
                    data: spi_in_d[DATA_MSB:0]};
        spi_wr_go <= 1'b1;
      end
    end
  end
  // ------------------------------------------------------------
  // UART port
  // ------------------------------------------------------------
  logic rx_valid;
  logic [7:0] rx_byte;
  logic tx_busy;
  logic tx_start_q;
  logic [7:0] tx_byte_q;
  logic [2:0] rx_cnt_q;
  logic [2:0] tx_cnt_q;
  logic [DGRAM_BITS-1:0] u_sh_q;
  logic [31:0] to_q;
  logic [DGRAM_BITS-1:0] reply_q;
  typedef enum logic [1:0] {U_RX, U_TX, U_WAIT} ustate_t;
  ustate_t ust_q;
  uart_char u_char (
    .mclk(mclk),
    .rst_n(rst_n),
    .bit_div(bit_div_q),
    .rxd_s(rxd_s),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .tx_start(tx_start_q),
    .tx_byte(tx_byte_q),
    .tx_busy(tx_busy),
    .txd(uart_txd)
  );
  wire [DGRAM_BITS-1:0] u_full = {u_sh_q[DGRAM_BITS-9:0], rx_byte};
  wire [31:0] u_rd = read_reg(u_full[ADDR_MSB:ADDR_LSB], ident_select_q, uart_rate_q);
  wire timed_out = (to_q == 32'(TIMEOUT_LIMIT));
  always_ff @(posedge mclk) begin
    uart_wr_go <= 1'b0;
    tx_start_q <= 1'b0;
    if (!rst_n) begin
      ust_q <= U_RX;
      rx_cnt_q <= 3'h0;
      tx_cnt_q <= 3'h0;
      u_sh_q <= '0;
      to_q <= 32'h0000_0000;
      reply_q <= '0;
      tx_byte_q <= 8'h00;
      uart_wr <= '0;
    end else begin
      unique case (ust_q)
        U_RX: begin
          if (rx_valid) begin
            to_q <= 32'h0000_0000;
            u_sh_q <= u_full;
            rx_cnt_q <= rx_cnt_q + 3'h1;
            if (rx_cnt_q == 3'(UART_BYTES - 1)) begin
              rx_cnt_q <= 3'h0;
              uart_wr <= '{wr: u_full[FLAG_POS], addr: u_full[ADDR_MSB:ADDR_LSB],
                           data: u_full[DATA_MSB:0]};
              uart_wr_go <= u_full[FLAG_POS];
              // Write reply content is meaningless, echo the frame
              reply_q <= u_full[FLAG_POS] ? u_full : {u_full[39:32], u_rd};
              tx_cnt_q <= 3'h0;
              ust_q <= U_TX;
            end
          end else if (rx_cnt_q != 3'h0) begin
            if (timed_out) begin
              rx_cnt_q <= 3'h0;
              to_q <= 32'h0000_0000;
            end else begin
              to_q <= to_q + 32'h0000_0001;
            end
          end
        end
        U_TX: begin
          if (!tx_busy && !tx_start_q) begin
            tx_byte_q <= reply_q[DGRAM_BITS-1:DGRAM_BITS-8];
            reply_q <= {reply_q[DGRAM_BITS-9:0], 8'h00};
            tx_start_q <= 1'b1;
            tx_cnt_q <= tx_cnt_q + 3'h1;
            ust_q <= U_WAIT;
          end
        end
        U_WAIT: begin
          if (!tx_busy && !tx_start_q) begin
            ust_q <= (tx_cnt_q == 3'(UART_BYTES)) ? U_RX : U_TX;
          end
        end
        default: ust_q <= U_RX;
      endcase
    end
  end
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_rate_reset: assert property (@(posedge mclk) $rose(rst_n) |-> uart_rate_q == UART_RATE_RESET)
    else $error("rate not 9600 after reset");
  a_rate_legal: assert property (@(posedge mclk) disable iff (!rst_n)
    uart_wr_go && uart_wr.addr == ADDR_UART_RATE && !rate_code_ok && !spi_rate_wr
    |=> $stable(uart_rate_q)) else $error("illegal rate code taken");
  a_rate_only_wr: assert property (@(posedge mclk) disable iff (!rst_n)
    !spi_rate_wr && !uart_rate_wr |=> $stable(uart_rate_q))
    else $error("rate changed without write");
  a_spi_write: assert property (@(posedge mclk) disable iff (!rst_n)
    spi_wr_go |-> spi_cnt_q == 6'(DGRAM_BITS)) else $error("write before 40 bits");
  a_spi_frame: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_n_s |=> spi_cnt_q == 6'h00) else $error("count not cleared by select");
  a_uart_timeout: assert property (@(posedge mclk) disable iff (!rst_n)
    ust_q == U_RX && timed_out && !rx_valid |=> rx_cnt_q == 3'h0)
    else $error("partial frame kept after timeout");
  a_uart_reply: assert property (@(posedge mclk) disable iff (!rst_n)
    ust_q == U_RX && rx_valid && rx_cnt_q == 3'h4 |=> ust_q == U_TX)
    else $error("no reply after five bytes");
  a_ident_sel: assert property (@(posedge mclk) disable iff (!rst_n)
    spi_sel_wr |=> ident_select_q == $past(spi_wr.data)) else $error("select not stored");
endmodule : dual_port_register_access

// ### hdl/regacc_pkg.sv
package regacc_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_IDENT_VALUE = 7'h00;
  localparam logic [6:0] ADDR_IDENT_SELECT = 7'h01;
  localparam logic [6:0] ADDR_UART_RATE = 7'h79;
  localparam logic [31:0] RATE_9600_CODE = 32'h0000_9600;
  localparam logic [31:0] RATE_115200_CODE = 32'h0011_5200;
  localparam logic [31:0] RATE_921600_CODE = 32'h0092_1600;
  localparam logic [31:0] RATE_3M_CODE = 32'h0300_0000;
  localparam logic [31:0] UART_RATE_RESET = RATE_9600_CODE;
  localparam logic [31:0] IDENT_SELECT_RESET = 32'h0000_0000;
  // Identification words; values are arbitrary
  localparam logic [31:0] IDENT_WORD0 = 32'h1234_5678;
  localparam logic [31:0] IDENT_WORD1 = 32'h0000_0001;
  localparam logic [31:0] IDENT_WORD2 = 32'h0000_0000;
  // ------------------------------------------------------------
  // Datagram layout
  // ------------------------------------------------------------
  localparam int DGRAM_BITS = 40;
  localparam int FLAG_POS = 39;
  localparam int ADDR_MSB = 38;
  localparam int ADDR_LSB = 32;
  localparam int DATA_MSB = 31;
  localparam int UART_BYTES = 5;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam longint CLK_HZ = 125000000;
  localparam longint TIMEOUT_MS = 1000;
  localparam longint TIMEOUT_CYCLES = CLK_HZ * TIMEOUT_MS / 1000;
  localparam logic [15:0] DIV_9600 = 16'(CLK_HZ / 9600);
  localparam logic [15:0] DIV_115200 = 16'(CLK_HZ / 115200);
  localparam logic [15:0] DIV_921600 = 16'(CLK_HZ / 921600);
  localparam logic [15:0] DIV_3M = 16'(CLK_HZ / 3000000);
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [31:0] data;
  } reg_req_t;
endpackage : regacc_pkg

// ### hdl/uart_char.sv
`timescale 1ns/1ps
module uart_char
  import regacc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] bit_div,
  input wire logic rxd_s,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  input wire logic tx_start,
  input wire logic [7:0] tx_byte,
  output logic tx_busy,
  output logic txd
);
  // ------------------------------------------------------------
  // Receiver: 1 start, 8 data, 1 stop, no parity
  // ------------------------------------------------------------
  logic [15:0] rcnt_q;
  logic [3:0] rbit_q;
  logic rbusy_q;
  logic [8:0] rsh_q;
  logic [15:0] tcnt_q;
  logic [3:0] tbit_q;
  logic [9:0] tsh_q;
  wire rtick = (rcnt_q == 16'h0000);
  wire ttick = (tcnt_q == 16'h0000);
  always_ff @(posedge mclk) begin
    rx_valid <= 1'b0;
    if (!rst_n) begin
      rbusy_q <= 1'b0;
      rcnt_q <= 16'h0000;
      rbit_q <= 4'h0;
      rsh_q <= 9'h000;
      rx_byte <= 8'h00;
    end else if (!rbusy_q) begin
      if (!rxd_s) begin
        // Sample mid-bit to tolerate rate error
        rbusy_q <= 1'b1;
        rcnt_q <= bit_div >> 1;
        rbit_q <= 4'h0;
      end
    end else if (rtick) begin
      rcnt_q <= bit_div - 16'h0001;
      if (rbit_q == 4'h0 && rxd_s) begin
        rbusy_q <= 1'b0;
      end else if (rbit_q == 4'h9) begin
        rbusy_q <= 1'b0;
        rx_valid <= rxd_s;
        rx_byte <= rsh_q[8:1];
      end else begin
        rsh_q <= {rxd_s, rsh_q[8:1]};
        rbit_q <= rbit_q + 4'h1;
      end
    end else begin
      rcnt_q <= rcnt_q - 16'h0001;
    end
  end
  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      txd <= 1'b1;
      tcnt_q <= 16'h0000;
      tbit_q <= 4'h0;
      tsh_q <= 10'h3FF;
    end else if (!tx_busy) begin
      txd <= 1'b1;
      if (tx_start) begin
        tx_busy <= 1'b1;
        tsh_q <= {1'b1, tx_byte, 1'b0};
        tbit_q <= 4'h0;
        tcnt_q <= 16'h0000;
      end
    end else if (ttick) begin
      tcnt_q <= bit_div - 16'h0001;
      if (tbit_q == 4'hA) begin
        tx_busy <= 1'b0;
      end else begin
        txd <= tsh_q[0];
        tsh_q <= {1'b1, tsh_q[9:1]};
        tbit_q <= tbit_q + 4'h1;
      end
    end else begin
      tcnt_q <= tcnt_q - 16'h0001;
    end
  end
endmodule : uart_char

// ### test/spi_main_model.sv
`timescale 1ns/1ps
module spi_main_model (
  output logic chip_select_n,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // ------------------------------------------------------------
  // Serial main frame driver
  // ------------------------------------------------------------
  initial begin
    chip_select_n = 1'b1;
    sck = 1'b1;
    mosi = 1'b0;
  end
  // Low phase longer than high so miso has cleared the sync stages
  task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
    chip_select_n = 1'b0;
    #70;
    for (int i = 39; i >= 0; i--) begin
      sck = 1'b0;
      mosi = tx[i];
      #40;
      sck = 1'b1;
      rx[i] = miso;
      #24;
      if (i == 32 && !tx[39]) #500;
    end
    #70;
    chip_select_n = 1'b1;
    mosi = ~mosi;
    #100;
  endtask : xfer
endmodule : spi_main_model

// ### test/dual_port_register_access_tb_top.sv
`timescale 1ns/1ps
module dual_port_register_access_tb_top;
  import regacc_pkg::*;
  // Short idle limit keeps the gap scenario brief
  localparam longint TOUT = 2000;
  localparam int BIT_CYC = int'(DIV_3M);
  logic mclk;
  logic rst_n;
  logic chip_select_n;
  logic sck;
  logic mosi;
  logic miso;
  logic uart_rxd;
  logic uart_txd;
  int miscompares;
  int checks_done;
  logic [39:0] r;

  dual_port_register_access #(.TIMEOUT_LIMIT(TOUT)) DUT (
    .mclk(mclk),
    .rst_n(rst_n),
    .chip_select_n(chip_select_n),
    .sck(sck),
    .mosi(mosi),
    .miso(miso),
    .uart_rxd(uart_rxd),
    .uart_txd(uart_txd)
  );
  spi_main_model MAIN (
    .chip_select_n(chip_select_n),
    .sck(sck),
    .mosi(mosi),
    .miso(miso)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic spi_wr(input logic [6:0] a, input logic [31:0] d);
    logic [39:0] f;
    MAIN.xfer({1'b1, a, d}, f);
    check("spi write top byte", {32'h0, f[39:32]}, 40'h0);
  endtask : spi_wr

  task automatic spi_rd(input logic [6:0] a, input logic [31:0] exp);
    logic [39:0] f;
    MAIN.xfer({1'b0, a, 32'hA5A5_5A5A}, f);
    check("spi read", f, {8'h00, exp});
  endtask : spi_rd

  task automatic uart_tx_byte(input logic [7:0] b);
    logic [9:0] s;
    s = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      uart_rxd = s[i];
      repeat (BIT_CYC) @(negedge mclk);
    end
  endtask : uart_tx_byte

  task automatic uart_rx(output logic [39:0] f);
    int n;
    f = '0;
    for (int k = 0; k < 5; k++) begin
      n = 0;
      while (uart_txd !== 1'b0 && n < 20000) begin
        @(negedge mclk);
        n++;
      end
      if (n == 20000) begin
        miscompares++;
        end_of_test();
      end
      repeat (BIT_CYC / 2) @(negedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(negedge mclk);
        // Each bit lands at its final place, so earlier bytes stay intact
        f[8 * (4 - k) + i] = uart_txd;
      end
      repeat (BIT_CYC) @(negedge mclk);
      check("uart stop bit", {39'h0, uart_txd}, 40'h1);
    end
  endtask : uart_rx

  task automatic uart_xfer(input logic [39:0] tx, output logic [39:0] rx);
    fork
      for (int k = 4; k >= 0; k--) uart_tx_byte(tx[8 * k +: 8]);
      uart_rx(rx);
    join
  endtask : uart_xfer

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_after_reset();
    spi_rd(ADDR_UART_RATE, RATE_9600_CODE);
    spi_rd(ADDR_IDENT_SELECT, IDENT_SELECT_RESET);
    spi_rd(ADDR_IDENT_VALUE, IDENT_WORD0);
  endtask : t_after_reset

  task automatic t_ident();
    spi_wr(ADDR_IDENT_SELECT, 32'h0000_0001);
    spi_rd(ADDR_IDENT_VALUE, IDENT_WORD1);
    spi_wr(ADDR_IDENT_SELECT, 32'h0000_0007);
    spi_rd(ADDR_IDENT_VALUE, 32'h0000_0000);
    spi_wr(7'h55, 32'hFFFF_FFFF);
    spi_rd(7'h55, 32'h0000_0000);
    spi_wr(ADDR_IDENT_SELECT, 32'h0000_0001);
  endtask : t_ident

  task automatic t_rate();
    logic [31:0] codes [4];
    codes = '{RATE_115200_CODE, RATE_921600_CODE, RATE_9600_CODE, RATE_3M_CODE};
    spi_wr(ADDR_UART_RATE, 32'h0000_1234);
    spi_rd(ADDR_UART_RATE, RATE_9600_CODE);
    for (int i = 0; i < 4; i++) begin
      spi_wr(ADDR_UART_RATE, codes[i]);
      spi_rd(ADDR_UART_RATE, codes[i]);
    end
  endtask : t_rate

  // UART writes first, then both ports active at once; neither may stall the other
  task automatic t_uart_cross();
    uart_xfer({8'h81, 32'h0000_0000}, r);
    // Illegal rate code over the UART port must leave the rate alone
    uart_xfer({8'hF9, 32'h0000_0001}, r);
    spi_rd(ADDR_UART_RATE, RATE_3M_CODE);
    spi_rd(ADDR_IDENT_VALUE, IDENT_WORD0);
    fork
      uart_xfer({8'h00, 32'h0000_0000}, r);
      spi_rd(ADDR_UART_RATE, RATE_3M_CODE);
    join
    check("uart read ident", r, {8'h00, IDENT_WORD0});
  endtask : t_uart_cross

  task automatic t_timeout();
    uart_tx_byte(8'h81);
    uart_tx_byte(8'h00);
    repeat (TOUT + 500) @(negedge mclk);
    uart_xfer({8'h01, 32'h0000_0000}, r);
    check("uart after idle gap", r, {8'h01, IDENT_SELECT_RESET});
  endtask : t_timeout

  initial begin
    rst_n = 1'b0;
    uart_rxd = 1'b1;
    miscompares = 0;
    checks_done = 0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
    t_after_reset();
    t_ident();
    t_rate();
    t_uart_cross();
    t_timeout();
    end_of_test();
  end

  // Hang guard
  initial begin
    #600000;
    miscompares++;
    end_of_test();
  end
endmodule : dual_port_register_access_tb_top
